// File: rtl/swid_dispatch.sv
// Wake-up decision and interrupt dispatch for an 8-bit controller.
// Assumes synchronous single-cycle event pulses and a core that acks vectors.
`timescale 1ns/1ps
module swid_dispatch #(
  parameter int unsigned WAKE_TAD = swid_pkg::CONV_WAKE_TAD
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_sleep_req,
  input  wire logic       i_global_irq_on_instr,
  input  wire logic       i_global_irq_off_instr,
  input  wire logic [3:0] i_irq_enable_reg,
  input  wire logic [3:0] i_wake_enable_reg,
  input  wire logic       i_ext_event,
  input  wire logic       i_pin_change,
  input  wire logic       i_timer_overflow,
  input  wire logic       i_conversion_done,
  input  wire logic       i_conversion_start,
  input  wire logic       i_tad_tick,
  input  wire logic [3:0] i_flag_clear,
  input  wire logic       i_vector_ack,
  output logic [3:0]      o_irq_flag_reg,
  output logic            o_global_irq,
  output logic            o_sleeping,
  output logic            o_clocks_halted,
  output logic            o_conversion_running,
  output logic            o_wake,
  output logic            o_vector_req,
  output logic [7:0]      o_vector_addr
);
  swid_pkg::swid_state_t state;
  swid_pkg::swid_state_t next_state;
  logic [3:0] flags;
  logic [3:0] next_flags;
  logic       gie;
  logic       next_gie;
  logic       running;
  logic       next_running;
  logic       halted;
  logic       next_halted;
  logic       sleeping;
  logic       next_sleeping;
  logic       wake;
  logic       next_wake;
  logic       vreq;
  logic       next_vreq;
  logic [7:0] vaddr;
  logic [7:0] next_vaddr;
  logic [3:0] tad_cnt;
  logic [3:0] next_tad_cnt;
  logic [3:0] set_ev;
  logic [3:0] eligible;
  logic       in_sleep;
  logic       chg_wake;
  logic       conv_wake;

  assign in_sleep  = (state != swid_pkg::SWID_RUN);
  assign chg_wake  = i_wake_enable_reg[swid_pkg::WAKE_CHANGE_BIT];
  assign conv_wake = i_wake_enable_reg[swid_pkg::WAKE_CONV_BIT];

  always_comb begin
    set_ev = 4'h0;
    // External pin is never a sleep event
    // Timer events are dropped in the conversion wait as well
    set_ev[swid_pkg::EXT_BIT] = i_ext_event && !in_sleep
                                && i_irq_enable_reg[swid_pkg::EXT_BIT];
    set_ev[swid_pkg::CHANGE_BIT] = i_pin_change
                                   && i_irq_enable_reg[swid_pkg::CHANGE_BIT];
    set_ev[swid_pkg::TIMER_BIT] = i_timer_overflow && !in_sleep
                                  && i_irq_enable_reg[swid_pkg::TIMER_BIT];
    set_ev[swid_pkg::CONV_BIT] = i_conversion_done
                                 && i_irq_enable_reg[swid_pkg::CONV_BIT];
    // Sleep entry without conversion wake aborts the conversion
    if (i_sleep_req && state == swid_pkg::SWID_RUN && !conv_wake && running
        && i_irq_enable_reg[swid_pkg::CONV_BIT]) begin
      set_ev[swid_pkg::CONV_BIT] = 1'b1;
    end
  end

  always_comb begin
    // A set in the same cycle as its clear wins
    next_flags = flags & ~i_flag_clear;
    next_flags = next_flags | set_ev;
    next_gie = gie;
    if (i_global_irq_on_instr) begin
      next_gie = 1'b1;
    end else if (i_global_irq_off_instr) begin
      next_gie = 1'b0;
    end
    next_running = running;
    if (i_conversion_start && !in_sleep) begin
      next_running = 1'b1;
    end
    if (i_conversion_done) begin
      next_running = 1'b0;
    end
    next_state   = state;
    next_halted  = halted;
    next_wake    = 1'b0;
    next_tad_cnt = tad_cnt;
    unique case (state)
      swid_pkg::SWID_RUN: begin
        if (i_sleep_req) begin
          next_state  = swid_pkg::SWID_SLEEP;
          // Converter wake needs its clock; otherwise everything stops
          next_halted = !conv_wake;
          if (!conv_wake) begin
            next_running = 1'b0;
          end
        end
      end
      swid_pkg::SWID_SLEEP: begin
        if (i_pin_change && chg_wake) begin
          next_state  = swid_pkg::SWID_RUN;
          next_halted = 1'b0;
          next_wake   = 1'b1;
        end else if (i_conversion_done && conv_wake) begin
          next_state   = swid_pkg::SWID_WAIT;
          // Four-bit count: WAKE_TAD above 16 would wrap
          next_tad_cnt = 4'(WAKE_TAD - 1);
        end
      end
      swid_pkg::SWID_WAIT: begin
        if (i_tad_tick) begin
          if (tad_cnt == 4'h0) begin
            next_state  = swid_pkg::SWID_RUN;
            next_halted = 1'b0;
            next_wake   = 1'b1;
          end else begin
            next_tad_cnt = tad_cnt - 4'h1;
          end
        end
      end
      default: begin
        next_state = swid_pkg::SWID_RUN;
      end
    endcase
    // Registered copy keeps the output straight off a flop
    next_sleeping = (next_state != swid_pkg::SWID_RUN);
  end

  // One vector at a time, fixed order: external, change, timer, conversion
  assign eligible = flags & i_irq_enable_reg & {4{gie}};
  always_comb begin
    next_vreq  = vreq;
    next_vaddr = vaddr;
    if (vreq) begin
      // Withdrawn on sleep; the flag stays, so it asks again after wake
      if (i_vector_ack || i_sleep_req) begin
        next_vreq = 1'b0;
      end
    end else if (!in_sleep && !i_sleep_req) begin
      // The core must clear the flag with its ack, or the vector repeats
      next_vreq = 1'b1;
      if (eligible[swid_pkg::EXT_BIT]) begin
        next_vaddr = swid_pkg::VEC_EXT;
      end else if (eligible[swid_pkg::CHANGE_BIT]) begin
        next_vaddr = swid_pkg::VEC_CHANGE;
      end else if (eligible[swid_pkg::TIMER_BIT]) begin
        next_vaddr = swid_pkg::VEC_TIMER;
      end else if (eligible[swid_pkg::CONV_BIT]) begin
        next_vaddr = swid_pkg::VEC_CONV;
      end else begin
        next_vreq = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state   <= swid_pkg::SWID_RUN;
      flags   <= swid_pkg::FLAGS_RESET;
      gie     <= 1'b0;
      running <= 1'b0;
      halted  <= 1'b0;
      sleeping <= 1'b0;
      wake    <= 1'b0;
      vreq    <= 1'b0;
      vaddr   <= swid_pkg::VEC_RESET;
      tad_cnt <= 4'h0;
    end else begin
      state   <= next_state;
      flags   <= next_flags;
      gie     <= next_gie;
      running <= next_running;
      halted  <= next_halted;
      sleeping <= next_sleeping;
      wake    <= next_wake;
      vreq    <= next_vreq;
      vaddr   <= next_vaddr;
      tad_cnt <= next_tad_cnt;
    end
  end

  assign o_irq_flag_reg       = flags;
  assign o_global_irq         = gie;
  assign o_sleeping           = sleeping;
  assign o_clocks_halted      = halted;
  assign o_conversion_running = running;
  assign o_wake               = wake;
  assign o_vector_req         = vreq;
  assign o_vector_addr        = vaddr;
endmodule

// File: rtl/swid_pkg.sv
// Package for the sleep wake-up and interrupt dispatch block.
// Assumes an 8-bit core that is offered a vector and acknowledges it.
package swid_pkg;
  // Enable and flag bit positions
  localparam int unsigned TIMER_BIT  = 0;
  localparam int unsigned CHANGE_BIT = 1;
  localparam int unsigned EXT_BIT    = 2;
  localparam int unsigned CONV_BIT   = 3;
  localparam int unsigned WAKE_CHANGE_BIT = 0;
  localparam int unsigned WAKE_CONV_BIT   = 2;
  // Vector addresses
  localparam logic [7:0] VEC_EXT    = 8'h03;
  localparam logic [7:0] VEC_CHANGE = 8'h06;
  localparam logic [7:0] VEC_TIMER  = 8'h09;
  localparam logic [7:0] VEC_CONV   = 8'h0c;
  localparam logic [7:0] VEC_RESET  = 8'h00;
  // Conversion wake-up delay in converter clock periods
  localparam int unsigned CONV_WAKE_TAD = 15;
  localparam logic [3:0]  FLAGS_RESET   = 4'h0;
  typedef enum logic [1:0] {
    SWID_RUN   = 2'b00,
    SWID_SLEEP = 2'b01,
    SWID_WAIT  = 2'b10
  } swid_state_t;
endpackage

// File: tb/swid_core_model.sv
// Core-side partner: takes each vector after a set delay.
// Assumes the request holds until acked.
`timescale 1ns/1ps
module swid_core_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_req,
  input  wire logic [7:0] i_addr,
  input  wire logic [3:0] i_delay,
  output logic            o_ack = 1'b0,
  output logic [3:0]      o_clr = 4'h0
);
  logic [3:0] cnt = 4'h0;
  always @(posedge i_clk_sys) begin
    o_ack <= 1'b0;
    o_clr <= 4'h0;
    cnt <= (i_req && !o_ack) ? cnt + 4'h1 : 4'h0;
    if (i_req && !o_ack && cnt >= i_delay) begin
      o_ack <= 1'b1;
      // Clear with the ack, else the same vector repeats
      o_clr <= {i_addr == 8'h0c, i_addr == 8'h03, i_addr == 8'h06, i_addr == 8'h09};
    end
  end
endmodule

// File: tb/swid_dispatch_props.sv
// Port-level checks for swid_dispatch.
// Assumes one clock and async high reset.
`timescale 1ns/1ps
module swid_dispatch_props #(parameter int unsigned WAKE_TAD = 15) (
  input wire logic       i_clk_sys,
  input wire logic       i_rst,
  input wire logic [3:0] i_irq_enable_reg,
  input wire logic [3:0] i_wake_enable_reg,
  input wire logic       i_ext_event,
  input wire logic       i_pin_change,
  input wire logic [3:0] i_flag_clear,
  input wire logic       i_vector_ack,
  input wire logic [3:0] o_irq_flag_reg,
  input wire logic       o_global_irq,
  input wire logic       o_sleeping,
  input wire logic       o_clocks_halted,
  input wire logic       o_wake,
  input wire logic       o_vector_req,
  input wire logic [7:0] o_vector_addr
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_wake;
    o_clocks_halted && i_pin_change && i_wake_enable_reg[0];
  endsequence
  sequence s_vec;
    s_wake ##0 (i_irq_enable_reg[1] && o_global_irq && !o_irq_flag_reg[2]);
  endsequence
  AST_EXT: assert property (
    o_clocks_halted && i_ext_event && !i_pin_change |=> o_sleeping) else $error("ext");
  AST_STAY: assert property (
    o_clocks_halted && i_pin_change && !i_wake_enable_reg[0] |=> o_sleeping) else $error("stay");
  AST_WAKE: assert property (
    s_wake |=> o_wake && !o_sleeping) else $error("wake");
  AST_VEC: assert property (
    s_vec |-> ##2 o_vector_req && o_vector_addr == swid_pkg::VEC_CHANGE) else $error("vec");
  AST_ELIG: assert property (
    $rose(o_vector_req) |-> $past(o_global_irq) && !$past(o_sleeping)) else $error("elig");
  AST_HALT: assert property (
    $rose(o_sleeping) |-> o_clocks_halted != $past(i_wake_enable_reg[2])) else $error("halt");
  AST_KEEP: assert property (
    ($past(o_irq_flag_reg) & ~$past(i_flag_clear) & ~o_irq_flag_reg) == 4'h0) else $error("keep");
  AST_ACK: assert property (
    o_vector_req && i_vector_ack |=> !o_vector_req) else $error("ack");
endmodule
bind swid_dispatch swid_dispatch_props #(.WAKE_TAD(WAKE_TAD)) u_props (.*);

// File: tb/tb_swid_dispatch.sv
// Self-checking bench for swid_dispatch with a core partner.
// Assumes outputs settle one edge after each sampled input.
`timescale 1ns/1ps
module tb_swid_dispatch;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [12:0] pls = 13'h0;
  logic [3:0]  ie = 4'h0, we = 4'h0, dly = 4'h0, clr, flg;
  logic        ack, sl, wk, hl, run, req, g, gq;
  logic [7:0]  va, w;
  logic [7:0]  exp_q[$];
  int          bad_count = 0, tests_run = 0, n;
  integer      seed = 32'h2bb2ce59;
  wire  [7:0]  st = {flg, sl, wk, hl, run};
  always #5 clk = ~clk;
  swid_dispatch #(.WAKE_TAD(2)) uut (.i_clk_sys(clk), .i_rst(rst), .i_sleep_req(pls[4]),
    .i_global_irq_on_instr(pls[5]), .i_global_irq_off_instr(pls[6]), .i_irq_enable_reg(ie),
    .i_wake_enable_reg(we), .i_ext_event(pls[0]), .i_pin_change(pls[1]),
    .i_timer_overflow(pls[2]), .i_conversion_done(pls[3]), .i_conversion_start(pls[7]),
    .i_tad_tick(pls[8]), .i_flag_clear(pls[12:9] | clr), .i_vector_ack(ack),
    .o_irq_flag_reg(flg), .o_global_irq(gq), .o_sleeping(sl), .o_clocks_halted(hl),
    .o_conversion_running(run), .o_wake(wk), .o_vector_req(req), .o_vector_addr(va));
  swid_core_model core (.i_clk_sys(clk), .i_req(req), .i_addr(va), .i_delay(dly),
    .o_ack(ack), .o_clr(clr));
  task automatic end_sim();
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    tests_run++;
    if (got !== want) begin
      bad_count++;
      $display("mismatch %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic p(input logic [12:0] v);
    @(posedge clk) pls <= v;
    @(posedge clk) pls <= 13'h0;
    @(negedge clk);
  endtask
  task automatic cfg(input logic [3:0] a, input logic [3:0] b);
    @(posedge clk) {ie, we} <= {a, b};
  endtask
  task automatic drain();
    for (n = 0; n < 60 && exp_q.size() > 0; n++) @(negedge clk);
    if (exp_q.size() > 0) begin
      bad_count++;
      $display("mismatch %0t vector missing", $time);
      end_sim();
    end
  endtask
  // Every taken vector is matched against the expected order
  always @(posedge clk) if (req === 1'b1 && ack === 1'b1) begin
    w = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
    chk(va, w);
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cfg(4'hf, 4'h0);
    p(13'h020);
    p(13'h00f);
    chk(st, 8'hf0);
    exp_q = '{8'h03, 8'h06, 8'h09, 8'h0c};
    drain();
    chk(st, 8'h00);
    cfg(4'hd, 4'h0);
    p(13'h002);
    repeat (5) @(negedge clk);
    chk(st, 8'h00);
    p(13'h1e00);
    cfg(4'h8, 4'h0);
    p(13'h080);
    chk(st, 8'h01);
    p(13'h010);
    chk(st, 8'h8a);
    p(13'h005);
    chk(st, 8'h8a);
    p(13'h002);
    chk(st, 8'h8a);
    cfg(4'ha, 4'h0);
    p(13'h002);
    chk(st, 8'haa);
    cfg(4'h8, 4'h1);
    exp_q = '{8'h0c};
    p(13'h002);
    chk(st, 8'ha4);
    drain();
    p(13'h400);
    cfg(4'h0, 4'h0);
    p(13'h080);
    p(13'h010);
    chk(st, 8'h0a);
    cfg(4'h0, 4'h1);
    p(13'h002);
    chk(st, 8'h04);
    cfg(4'h2, 4'h1);
    for (int i = 0; i < 4; i++) begin
      g = 1'($random(seed));
      dly <= 4'($random(seed) & 3);
      p(g ? 13'h020 : 13'h040);
      chk({7'h0, gq}, {7'h0, g});
      p(13'h010);
      chk(st, 8'h0a);
      if (g) exp_q = '{8'h06};
      p(13'h002);
      chk(st, 8'h24);
      drain();
      if (!g) p(13'h400);
    end
    cfg(4'h0, 4'h4);
    p(13'h080);
    p(13'h010);
    chk(st, 8'h09);
    p(13'h008);
    p(13'h100);
    chk({7'h0, sl}, 8'h01);
    p(13'h100);
    for (n = 0; n < 4 && wk !== 1'b1; n++) @(negedge clk);
    chk({7'h0, wk}, 8'h01);
    end_sim();
  end
endmodule
